/* File: src/tfs_pkg.sv */
// telemetry frame status fields: shared constants and types
// assumes a 100 MHz core clock and a plain strobe register port
package tfs_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TRACK = 4'h1;
  localparam logic [3:0] REG_GIMBAL = 4'h2;
  localparam logic [3:0] REG_ZOOM = 4'h3;
  localparam logic [3:0] REG_PICTURE = 4'h4;
  localparam logic [3:0] REG_MISS_H = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_FRAMES = 4'h7;
  localparam logic [3:0] REG_SUM = 4'h8;

  // ****************************************
  // field layout, masks, reset values
  // ****************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_OVR_BIT = 0;
  localparam int STAT_STATE_LSB = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam logic [15:0] TRACK_MASK = 16'h00FC;
  localparam logic [15:0] GIMBAL_MASK = 16'h00BF;
  localparam logic [15:0] ZOOM_MASK = 16'h0FFF;
  localparam logic [15:0] PIC_MASK = 16'h000F;
  localparam logic [15:0] FIELD_RESET = 16'h0000;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [7:0] SYNC_0 = 8'hEE;
  localparam logic [7:0] SYNC_1 = 8'h16;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int FRAME_RATE_HZ = 60;
  // whole cycles per frame; the dropped fraction is about 0.4 parts per million
  localparam int FRAME_CYCLES = CLK_FREQ_HZ / FRAME_RATE_HZ;

  typedef enum logic [1:0] {
    TFS_IDLE = 2'b00,
    TFS_EMIT = 2'b01,
    TFS_SUM = 2'b11
  } tfs_state_t;

endpackage : tfs_pkg

/* File: src/tfs_framer.sv */
// telemetry frame head builder: bytes 0..7 plus running checksum
// assumes software on the same clock and a byte sink with valid/ready
// Notes on behaviour
// - byte 2 bits 7-6 tracking source
// - byte 2 bits 5-4 tracking algorithm
// - byte 2 bit 3 prompt, bits 1-0 zero
// - byte 2 bit 2 lock versus search
// - byte 3 enhance, storage; bit 6 zero
// - byte 3 bit 4 roll axis mode
// - byte 3 motor, follow, lock, laser flags
// - zoom low byte 4, high nibble byte 5
// - byte 5 bits 7-6 large picture source
// - byte 5 bits 5-4 small picture source
// - bytes 6,7 signed horizontal miss
// - running byte sum feeds final checksum
`timescale 1ns/1ps

// ****************************************
// byte fifo with registered output
// ****************************************
module tfs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg, rd_ptr_reg;
  logic full, empty, push, pop;

  // full when pointers differ only in the wrap bit
  assign full = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;
  // refill the output stage whenever it is free or being taken
  assign pop = !empty && (!out_valid_o || out_ready_i);

  // storage array, no reset needed
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // output stage keeps out_valid_o and out_data_o flip-flops; in_ready_o is decoded from the pointers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr_reg[AW-1:0]];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule : tfs_fifo

// ****************************************
// frame head builder
// ****************************************
module tfs_framer #(
  parameter int FRAME_CYCLES = tfs_pkg::FRAME_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [7:0] byte_data_o,
  output logic byte_first_o,
  output logic byte_valid_o,
  input wire logic byte_ready_i,
  output logic [7:0] sum_o,
  output logic sum_valid_o
);
  if (FRAME_CYCLES < 16) begin : g_bad_period
    $error("frame period too short for eight bytes");
  end
  tfs_pkg::tfs_state_t state_reg;
  logic [31:0] timer_reg;
  logic [15:0] ctrl_reg, track_reg, gimbal_reg, zoom_reg, pic_reg, miss_reg, frames_reg, snap_miss, rdata_next;
  logic [11:0] snap_zoom;
  logic [7:0] snap_track, snap_gimbal, run_sum_reg, push_data;
  logic [3:0] snap_pic;
  logic [2:0] idx_reg;
  logic tick, ovr_reg, push_ready, push_fire, start;
  default clocking tfs_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // modulo-256 add used by the running sum path
  function automatic logic [7:0] tfs_add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction : tfs_add8

  // ****************************************
  // frame timer
  // ****************************************
  // timer starts at the top so the first frame leaves at release
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_reg <= 32'(FRAME_CYCLES - 1);
    end else if (!ctrl_reg[tfs_pkg::CTRL_EN_BIT]) begin
      timer_reg <= 32'(FRAME_CYCLES - 1);
    end else if (tick) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 32'h0000_0001;
    end
  end

  assign tick = ctrl_reg[tfs_pkg::CTRL_EN_BIT] && timer_reg == 32'(FRAME_CYCLES - 1);
  // a tick while a frame is still draining is dropped, not queued
  assign start = tick && state_reg == tfs_pkg::TFS_IDLE;

  // ****************************************
  // register writes
  // ****************************************
  // enable resets on so frames flow without any request
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= tfs_pkg::CTRL_RESET;
      track_reg <= tfs_pkg::FIELD_RESET;
      gimbal_reg <= tfs_pkg::FIELD_RESET;
      zoom_reg <= tfs_pkg::FIELD_RESET;
      pic_reg <= tfs_pkg::FIELD_RESET;
      miss_reg <= tfs_pkg::FIELD_RESET;
    end else if (wr_i) begin
      unique case (addr_i)
        tfs_pkg::REG_CTRL: ctrl_reg <= wdata_i & tfs_pkg::CTRL_RESET;
        tfs_pkg::REG_TRACK: track_reg <= wdata_i & tfs_pkg::TRACK_MASK;
        tfs_pkg::REG_GIMBAL: gimbal_reg <= wdata_i & tfs_pkg::GIMBAL_MASK;
        tfs_pkg::REG_ZOOM: zoom_reg <= wdata_i & tfs_pkg::ZOOM_MASK;
        tfs_pkg::REG_PICTURE: pic_reg <= wdata_i & tfs_pkg::PIC_MASK;
        tfs_pkg::REG_MISS_H: miss_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  // overrun flag: write one to clear, a new overrun wins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovr_reg <= 1'b0;
    end else if (tick && state_reg != tfs_pkg::TFS_IDLE) begin
      ovr_reg <= 1'b1;
    end else if (wr_i && addr_i == tfs_pkg::REG_STATUS && wdata_i[tfs_pkg::STAT_OVR_BIT]) begin
      ovr_reg <= 1'b0;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb begin
    rdata_next = '0;
    unique case (addr_i)
      tfs_pkg::REG_CTRL: rdata_next = ctrl_reg;
      tfs_pkg::REG_TRACK: rdata_next = track_reg;
      tfs_pkg::REG_GIMBAL: rdata_next = gimbal_reg;
      tfs_pkg::REG_ZOOM: rdata_next = zoom_reg;
      tfs_pkg::REG_PICTURE: rdata_next = pic_reg;
      tfs_pkg::REG_MISS_H: rdata_next = miss_reg;
      tfs_pkg::REG_STATUS: begin
        rdata_next[tfs_pkg::STAT_OVR_BIT] = ovr_reg;
        rdata_next[tfs_pkg::STAT_STATE_LSB +: 2] = state_reg;
      end
      tfs_pkg::REG_FRAMES: rdata_next = frames_reg;
      tfs_pkg::REG_SUM: rdata_next = {8'h00, sum_o};
      default: rdata_next = '0;
    endcase
  end
  // read data lives for the one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rdata_next : '0;
    end
  end

  // ****************************************
  // snapshot
  // ****************************************
  // fields are frozen at frame start so one frame never mixes updates
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      snap_track <= '0;
      snap_gimbal <= '0;
      snap_zoom <= '0;
      snap_pic <= '0;
      snap_miss <= '0;
    end else if (start) begin
      snap_track <= track_reg[7:0];
      snap_gimbal <= gimbal_reg[7:0];
      snap_zoom <= zoom_reg[11:0];
      snap_pic <= pic_reg[3:0];
      snap_miss <= miss_reg;
    end
  end

  // ****************************************
  // byte sequencer
  // ****************************************
  always_comb begin
    push_data = '0;
    unique case (idx_reg)
      3'h0: push_data = tfs_pkg::SYNC_0;
      3'h1: push_data = tfs_pkg::SYNC_1;
      3'h2: push_data = {snap_track[7:2], 2'b00};
      3'h3: push_data = {snap_gimbal[7], 1'b0, snap_gimbal[5:0]};
      3'h4: push_data = snap_zoom[7:0];
      3'h5: push_data = {snap_pic, snap_zoom[11:8]};
      3'h6: push_data = snap_miss[7:0];
      3'h7: push_data = snap_miss[15:8];
    endcase
  end
  assign push_fire = state_reg == tfs_pkg::TFS_EMIT && push_ready; // buffer has room
  // state, byte index and running sum
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= tfs_pkg::TFS_IDLE;
      idx_reg <= '0;
      run_sum_reg <= '0;
    end else begin
      unique case (state_reg)
        tfs_pkg::TFS_IDLE: begin
          if (start) begin
            state_reg <= tfs_pkg::TFS_EMIT;
            idx_reg <= '0;
            run_sum_reg <= '0;
          end
        end
        tfs_pkg::TFS_EMIT: begin
          if (push_fire) begin
            run_sum_reg <= tfs_add8(run_sum_reg, push_data);
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == tfs_pkg::LAST_BYTE) begin
              state_reg <= tfs_pkg::TFS_SUM;
            end
          end
        end
        tfs_pkg::TFS_SUM: state_reg <= tfs_pkg::TFS_IDLE;
        default: state_reg <= tfs_pkg::TFS_IDLE;
      endcase
    end
  end

  // ****************************************
  // checksum hand-off and frame count
  // ****************************************
  // the rest of the frame continues this sum up to its last byte
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sum_o <= '0;
      sum_valid_o <= 1'b0;
      frames_reg <= '0;
    end else if (state_reg == tfs_pkg::TFS_SUM) begin
      sum_o <= run_sum_reg;
      sum_valid_o <= 1'b1;
      frames_reg <= frames_reg + 16'h0001;
    end else begin
      sum_valid_o <= 1'b0;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  // back-pressure from the sink stalls the sequencer, not the timer
  tfs_fifo #(
    .WIDTH(tfs_pkg::FIFO_WIDTH),
    .DEPTH(tfs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(state_reg == tfs_pkg::TFS_EMIT),
    .in_ready_o(push_ready),
    .in_data_i({idx_reg == 3'h0, push_data}),
    .out_valid_o(byte_valid_o),
    .out_ready_i(byte_ready_i),
    .out_data_o({byte_first_o, byte_data_o})
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_push(int k);
    push_fire && idx_reg == 3'(k);
  endsequence
  property p_start;
    start |=> state_reg == tfs_pkg::TFS_EMIT && idx_reg == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start on tick");
  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_sync;
    s_push(0) |-> push_data == tfs_pkg::SYNC_0 ##1 (!push_fire || push_data == tfs_pkg::SYNC_1);
  endproperty
  a_sync: assert property (p_sync) else $error("sync bytes wrong");
  property p_byte2;
    s_push(2) |-> push_data[1:0] == 2'b00 && push_data[7:2] == snap_track[7:2];
  endproperty
  a_byte2: assert property (p_byte2) else $error("byte 2 wrong");
  property p_byte3;
    s_push(3) |-> !push_data[6] && {push_data[7], push_data[5:0]} == {snap_gimbal[7], snap_gimbal[5:0]};
  endproperty
  a_byte3: assert property (p_byte3) else $error("byte 3 wrong");
  property p_zoom;
    s_push(5) |-> push_data[3:0] == snap_zoom[11:8] && $stable(snap_zoom);
  endproperty
  a_zoom: assert property (p_zoom) else $error("zoom high nibble wrong");
  property p_pic;
    s_push(5) |-> push_data[7:6] == snap_pic[3:2] && push_data[5:4] == snap_pic[1:0];
  endproperty
  a_pic: assert property (p_pic) else $error("picture sources wrong");
  property p_miss;
    s_push(7) |-> push_data == snap_miss[15:8] ##1 state_reg == tfs_pkg::TFS_SUM;
  endproperty
  a_miss: assert property (p_miss) else $error("miss high byte wrong");
  property p_sum;
    state_reg == tfs_pkg::TFS_SUM |=> sum_valid_o && sum_o == $past(run_sum_reg) ##1 !sum_valid_o;
  endproperty
  a_sum: assert property (p_sum) else $error("checksum hand-off wrong");
  property p_ovr;
    tick && state_reg != tfs_pkg::TFS_IDLE |=> ovr_reg;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
endmodule : tfs_framer

/* File: sim/tfs_sink.sv */
// byte sink model: the controller receiving the telemetry head
// assumes valid/ready transfer on the rising edge of core_clk_i
`timescale 1ns/1ps

// ****************************************
// controller-side byte receiver
// ****************************************
module tfs_sink (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] byte_data_i,
  input wire logic byte_first_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  input wire logic [1:0] mode_i,
  output logic [7:0] sum_acc_o
);
  logic [8:0] got[$];
  logic phase_reg;

  // mode 0 always ready, 1 every other cycle, 2 stalled
  assign byte_ready_o = (mode_i == 2'h0) || ((mode_i == 2'h1) && phase_reg);

  // capture bytes; first flag restarts the running sum so a frame is found by its first flag, not by its sync pair
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg <= 1'b0;
      sum_acc_o <= 8'h00;
    end else begin
      phase_reg <= ~phase_reg;
      if (byte_valid_i && byte_ready_o) begin
        got.push_back({byte_first_i, byte_data_i});
        sum_acc_o <= byte_first_i ? byte_data_i : sum_acc_o + byte_data_i;
      end
    end
  end
endmodule : tfs_sink

/* File: sim/tfs_framer_test.sv */
// testbench for the telemetry frame head builder
// assumes the sink model and design files are compiled first
`timescale 1ns/1ps

module tfs_framer_test;
  localparam int FC = 40;
  logic core_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, byte_ready_i;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, d, f0;
  logic [7:0] byte_data_o, sum_o, sum_acc, sum_q, e[8];
  logic byte_first_o, byte_valid_o, sum_valid_o;
  logic [1:0] mode = 2'h0;
  int n_fail = 0, cmp_count = 0, cyc = 0, last_cyc = 0, gap = 0;
  localparam logic [11:0] ZL [4] = '{12'hFFF, 12'h000, 12'h032, 12'hA5C};
  localparam logic [15:0] ML [4] = '{16'h8001, 16'h7FFF, 16'h0000, 16'hFFEC};
  localparam logic [7:0] GL [4] = '{8'hFF, 8'h00, 8'hAA, 8'h55};

  tfs_framer #(.FRAME_CYCLES(FC)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .byte_data_o(byte_data_o),
    .byte_first_o(byte_first_o), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
    .sum_o(sum_o), .sum_valid_o(sum_valid_o));
  tfs_sink u_sink (.core_clk_i(core_clk_i), .reset_i(reset_i), .byte_data_i(byte_data_o),
    .byte_first_i(byte_first_o), .byte_valid_i(byte_valid_o), .byte_ready_o(byte_ready_i),
    .mode_i(mode), .sum_acc_o(sum_acc));

  // ****************************************
  // clock, timeout, checksum pulse watch
  // ****************************************
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // gap between checksum pulses shows the frame period
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (sum_valid_o === 1'b1) begin
      sum_q <= sum_o;
      gap <= cyc - last_cyc;
      last_cyc <= cyc;
    end
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : reg_rd

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
    chk16({7'h00, got}, {7'h00, exp});
  endtask : chk9

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cycles

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    int w;
    logic [1:0] src, alg;
    cycles(20);
    reset_i <= 1'b0;
    // register defaults and an unmapped place
    reg_rd(tfs_pkg::REG_CTRL, d);
    chk16(d, tfs_pkg::CTRL_RESET);
    reg_rd(tfs_pkg::REG_ZOOM, d);
    chk16(d, tfs_pkg::FIELD_RESET);
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(4'hF, d);
    chk16(d, 16'h0000);
    $display("test registers done");

    // every source, algorithm and flag code, reserved bits except gimbal bit 6 written as ones
    for (int i = 0; i < 4; i++) begin
      src = i[1:0];
      alg = 2'(3 - i);
      reg_wr(tfs_pkg::REG_CTRL, 16'h0000);
      cycles(40);
      u_sink.got.delete();
      mode <= (i == 1) ? 2'h1 : 2'h0;
      reg_wr(tfs_pkg::REG_TRACK, {8'hFF, src, alg, i[0], ~i[0], 2'b11});
      reg_wr(tfs_pkg::REG_GIMBAL, {8'hFF, GL[i]});
      reg_wr(tfs_pkg::REG_ZOOM, {4'hF, ZL[i]});
      reg_wr(tfs_pkg::REG_PICTURE, {12'hFFF, src, 2'(i + 1)});
      reg_wr(tfs_pkg::REG_MISS_H, ML[i]);
      e = '{8'hEE, 8'h16, {src, alg, i[0], ~i[0], 2'b00}, GL[i] & 8'hBF, ZL[i][7:0],
            {src, 2'(i + 1), ZL[i][11:8]}, ML[i][7:0], ML[i][15:8]};
      reg_wr(tfs_pkg::REG_CTRL, 16'h0001);
      w = 0;
      while (u_sink.got.size() < 8 && w < 200) begin
        cycles(1);
        w++;
      end
      cycles(3);
      chk16(16'(u_sink.got.size()), 16'd8);
      for (int k = 0; k < 8; k++) begin
        chk9(u_sink.got[k], {k == 0, e[k]});
      end
      chk16({8'h00, sum_q}, {8'h00, e[0] + e[1] + e[2] + e[3] + e[4] + e[5] + e[6] + e[7]});
      chk16({8'h00, sum_acc}, {8'h00, sum_q});
      reg_rd(tfs_pkg::REG_SUM, d);
      chk16(d, {8'h00, sum_q});
      $display("test frame %0d done", i);
    end

    // unrequested frames repeat with the frame period
    // frame counter advances by exactly three over three periods
    mode <= 2'h0;
    reg_rd(tfs_pkg::REG_FRAMES, f0);
    cycles(3 * FC - 2);
    reg_rd(tfs_pkg::REG_FRAMES, d);
    chk16(d, f0 + 16'h0003);
    chk16(16'(gap), 16'(FC));
    $display("test period done");

    // stalled sink fills the buffer; later ticks find the frame unfinished
    mode <= 2'h2;
    cycles(6 * FC);
    chk16({15'h0000, byte_valid_o}, 16'h0001);
    reg_rd(tfs_pkg::REG_STATUS, d);
    chk16(d & 16'h0001, 16'h0001);
    mode <= 2'h0;
    cycles(60);
    reg_wr(tfs_pkg::REG_STATUS, 16'h0001);
    reg_rd(tfs_pkg::REG_STATUS, d);
    chk16(d & 16'h0001, 16'h0000);
    $display("test overrun done");
    close_out();
  end
endmodule : tfs_framer_test
